// file: common/lsts_regs.vh
// Register map, field positions, error codes and timing constants
// Assumes a 100 MHz core clock and a 32-bit APB register bus
`ifndef LSTS_REGS_VH
`define LSTS_REGS_VH

// Register byte offsets
`define LSTS_CTRL        8'h00
`define LSTS_WAIT_TMO    8'h04
`define LSTS_PULSE       8'h08
`define LSTS_LOOP        8'h0C
`define LSTS_POINT       8'h10
`define LSTS_DWELL       8'h14
`define LSTS_POS         8'h18
`define LSTS_ERR         8'h1C
`define LSTS_STATUS      8'h20
`define LSTS_MASK        8'h24
`define LSTS_LEVEL       8'h28
`define LSTS_LEN         8'h2C

// Control fields
`define LSTS_CTRL_RUN    0
`define LSTS_CTRL_VOLT   1
`define LSTS_CTRL_CURR   2
`define LSTS_CTRL_CLEAR  3
`define LSTS_PULSE_ON    31

// Step kinds in bits 17:16 of a point
`define LSTS_K_DWELL     2'h0
`define LSTS_K_WHIGH     2'h1
`define LSTS_K_WLOW      2'h2
`define LSTS_K_TRIG      2'h3

// Status bits
`define LSTS_ST_ERR      0
`define LSTS_ST_STEP     1
`define LSTS_ST_DONE     2
`define LSTS_ST_TMO      3

// Error codes as 16-bit two's complement
`define LSTS_ERR_CONFLICT 16'hFF23
`define LSTS_ERR_LENGTH   16'hFF1E

// Times
`define LSTS_CLK_NS      10
`define LSTS_TICK_NS     10000
`define LSTS_TICK_CYC    (`LSTS_TICK_NS / `LSTS_CLK_NS)
`define LSTS_FILT_NS     400000
`define LSTS_FILT_CYC    (`LSTS_FILT_NS / `LSTS_CLK_NS)
`define LSTS_TICK_US     16'h000A
`define LSTS_WAIT_MIN_US 16'h00FA
`define LSTS_WAIT_MAX_US 16'h80E8
`define LSTS_PUL_MAX_US  16'h84D0
`define LSTS_LVL_MIN_US  16'h0BB8
`define LSTS_WAIT_MIN_T  (`LSTS_WAIT_MIN_US / `LSTS_TICK_US)
`define LSTS_WAIT_MAX_T  (`LSTS_WAIT_MAX_US / `LSTS_TICK_US)
`define LSTS_PUL_MAX_T   (`LSTS_PUL_MAX_US / `LSTS_TICK_US)
`define LSTS_LVL_MIN_T   ((`LSTS_LVL_MIN_US + `LSTS_TICK_US - 16'h0001) / `LSTS_TICK_US)
`define LSTS_LVL_POINTS  4'hA

`endif

// file: logic/lsts_trig_filter.v
// Trigger input synchroniser and stability filter
// Assumes an asynchronous pin; level accepted after FILT_CYC stable cycles
`timescale 1ns/1ps
module lsts_trig_filter #(
    parameter FILT_CYC = 40000
) (
    input  wire i_clk,
    input  wire i_nrst,
    input  wire i_pin,
    output reg  o_level
);
    reg        s1_r;
    reg        s2_r;
    reg [31:0] cnt_r;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r    <= 1'b1;
            s2_r    <= 1'b1;
            cnt_r   <= 32'h00000000;
            o_level <= 1'b1;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            // Level must hold for the full window
            if (s2_r == o_level) begin
                cnt_r <= 32'h00000000;
            end else if (cnt_r >= FILT_CYC - 1) begin
                cnt_r   <= 32'h00000000;
                o_level <= s2_r;
            end else begin
                cnt_r <= cnt_r + 32'h00000001;
            end
        end
    end
endmodule

// file: logic/lsts_sequencer.v
// List step sequencer with trigger waits, flag pulse and APB registers
// Assumes APB master on I_REF_CLK; trigger pin is asynchronous
`timescale 1ns/1ps
`include "lsts_regs.vh"

// What this block does
// - Wait timeout read back, clamped 0.25 to 33 ms
// - Timeout reads zero until set, waits forever
// - Triggered step sets level and pulses flag
// - Triggered point without pulse setup posts -221
// - Point without list type posts -221
// - Triggered point with unequal lengths posts -226
// - Wait high then low advances on falling edge
// - Wait high ends on high or timeout
// - List runs for the loop count
// - Repeat loops start after skipped points
// - Level below 3 ms uses ten points
// - Stepping only in run mode
// - Chained wait steps add their timeouts
// - Trigger level valid after 0.4 ms stable
// - Pulse setup owns flag until list clear
module lsts_sequencer #(
    parameter AW       = 6,
    parameter FILT_CYC = `LSTS_FILT_CYC
) (
    input  wire        I_REF_CLK,
    input  wire        I_NRST,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    input  wire        I_TRIGGER_IN,
    input  wire        I_OUTPUT_OFF,
    output reg  [15:0] O_LEVEL,
    output reg         O_FLAG_TRANSISTOR_ON,
    output reg         O_RUNNING,
    output reg         O_IRQ
);
    localparam DEPTH  = 1 << AW;
    localparam S_IDLE = 6'h01;
    localparam S_LOAD = 6'h02;
    localparam S_DWEL = 6'h04;
    localparam S_WHI  = 6'h08;
    localparam S_WLO  = 6'h10;
    localparam S_DONE = 6'h20;

    // Clamp a nonzero tick count into a range
    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v == 16'h0000)
                clamp = 16'h0000;
            else if (v < lo)
                clamp = lo;
            else if (v > hi)
                clamp = hi;
            else
                clamp = v;
        end
    endfunction

    // Counter reaches its end on this tick
    function expired;
        input [15:0] c;
        begin
            expired = (c <= 16'h0001);
        end
    endfunction

    reg  [17:0]   val_mem [0:DEPTH-1];
    reg  [15:0]   dwl_mem [0:DEPTH-1];
    reg  [AW:0]   set_len_r;
    reg  [AW:0]   dwl_len_r;
    reg           run_r;
    reg           volt_r;
    reg           curr_r;
    reg  [15:0]   wait_tmo_r;
    reg  [15:0]   pulse_w_r;
    reg           pulse_on_r;
    reg           pulse_set_r;
    reg  [15:0]   loops_r;
    reg  [15:0]   skip_r;
    reg  [15:0]   err_r;
    reg  [3:0]    sts_r;
    reg  [3:0]    mask_r;
    reg  [3:0]    fill_left_r;
    reg  [17:0]   fill_val_r;
    reg  [15:0]   fill_dwl_r;
    reg  [15:0]   tick_cnt_r;
    reg           tick_r;
    reg  [5:0]    state_r;
    reg  [AW-1:0] idx_r;
    reg  [15:0]   loop_r;
    reg  [15:0]   step_cnt_r;
    reg  [15:0]   pulse_cnt_r;
    reg           pulse_act_r;
    reg  [3:0]    ev_nxt;
    reg           adv;
    wire          trig_f;
    wire          acc;
    wire          wr;
    wire          full;
    wire [17:0]   cur_pt;
    wire          typed;
    wire [15:0]   lvl_dur;
    integer       i;

    assign acc    = I_PSEL & I_PENABLE & O_PREADY;
    assign wr     = acc & I_PWRITE & ~O_PSLVERR;
    assign full   = (set_len_r == DEPTH[AW:0]) | (dwl_len_r == DEPTH[AW:0]);
    assign cur_pt = val_mem[idx_r];
    assign typed  = volt_r | curr_r;
    assign lvl_dur = I_PWDATA[31:16];

    lsts_trig_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_filt (
        .i_clk   (I_REF_CLK),
        .i_nrst  (I_NRST),
        .i_pin   (I_TRIGGER_IN),
        .o_level (trig_f)
    );

    // APB slave: one wait state, errors on unmapped offsets
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h00000000;
        end else begin
            O_PREADY  <= I_PSEL & I_PENABLE & ~O_PREADY;
            O_PSLVERR <= 1'b0;
            if (I_PSEL & I_PENABLE & ~O_PREADY) begin
                O_PRDATA <= 32'h00000000;
                case (I_PADDR)
                    `LSTS_CTRL:     O_PRDATA <= {28'h0, 1'b0, curr_r, volt_r, run_r};
                    `LSTS_WAIT_TMO: O_PRDATA <= {16'h0000, wait_tmo_r};
                    `LSTS_PULSE:    O_PRDATA <= {pulse_on_r, pulse_set_r, 14'h0, pulse_w_r};
                    `LSTS_LOOP:     O_PRDATA <= {skip_r, loops_r};
                    `LSTS_POS:      O_PRDATA <= {loop_r, {(16-AW){1'b0}}, idx_r};
                    `LSTS_ERR:      O_PRDATA <= {16'h0000, err_r};
                    `LSTS_STATUS:   O_PRDATA <= {28'h0, sts_r};
                    `LSTS_MASK:     O_PRDATA <= {28'h0, mask_r};
                    `LSTS_LEN:      O_PRDATA <= {{(15-AW){1'b0}}, dwl_len_r,
                                                 {(15-AW){1'b0}}, set_len_r};
                    `LSTS_POINT, `LSTS_DWELL, `LSTS_LEVEL: O_PRDATA <= 32'h00000000;
                    default: O_PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // Configuration, list storage and error reporting
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            run_r       <= 1'b0;
            volt_r      <= 1'b0;
            curr_r      <= 1'b0;
            wait_tmo_r  <= 16'h0000;
            pulse_w_r   <= 16'h0000;
            pulse_on_r  <= 1'b0;
            pulse_set_r <= 1'b0;
            loops_r     <= 16'h0001;
            skip_r      <= 16'h0000;
            err_r       <= 16'h0000;
            set_len_r   <= {(AW+1){1'b0}};
            dwl_len_r   <= {(AW+1){1'b0}};
            fill_left_r <= 4'h0;
            fill_val_r  <= 18'h00000;
            fill_dwl_r  <= 16'h0000;
            mask_r      <= 4'h0;
        end else begin
            if (fill_left_r != 4'h0 && !full) begin
                val_mem[set_len_r[AW-1:0]] <= fill_val_r;
                dwl_mem[dwl_len_r[AW-1:0]] <= fill_dwl_r;
                set_len_r   <= set_len_r + 1'b1;
                dwl_len_r   <= dwl_len_r + 1'b1;
                fill_left_r <= fill_left_r - 4'h1;
            end else if (fill_left_r != 4'h0) begin
                fill_left_r <= 4'h0;
            end
            if (wr) begin
                case (I_PADDR)
                    `LSTS_CTRL: begin
                        run_r <= I_PWDATA[`LSTS_CTRL_RUN];
                        if (I_PWDATA[`LSTS_CTRL_VOLT])
                            volt_r <= 1'b1;
                        if (I_PWDATA[`LSTS_CTRL_CURR])
                            curr_r <= 1'b1;
                        if (I_PWDATA[`LSTS_CTRL_CLEAR]) begin
                            volt_r      <= 1'b0;
                            curr_r      <= 1'b0;
                            pulse_set_r <= 1'b0;
                            set_len_r   <= {(AW+1){1'b0}};
                            dwl_len_r   <= {(AW+1){1'b0}};
                            fill_left_r <= 4'h0;
                        end
                    end
                    `LSTS_WAIT_TMO: wait_tmo_r <= clamp(I_PWDATA[15:0],
                        `LSTS_WAIT_MIN_T, `LSTS_WAIT_MAX_T);
                    `LSTS_PULSE: begin
                        pulse_w_r   <= clamp(I_PWDATA[15:0],
                            `LSTS_WAIT_MIN_T, `LSTS_PUL_MAX_T);
                        pulse_on_r  <= I_PWDATA[`LSTS_PULSE_ON];
                        pulse_set_r <= 1'b1;
                    end
                    `LSTS_LOOP: begin
                        loops_r <= I_PWDATA[15:0];
                        skip_r  <= I_PWDATA[31:16];
                    end
                    `LSTS_POINT: begin
                        if (I_PWDATA[17:16] == `LSTS_K_TRIG && !pulse_set_r)
                            err_r <= `LSTS_ERR_CONFLICT;
                        else if (!typed)
                            err_r <= `LSTS_ERR_CONFLICT;
                        else if (I_PWDATA[17:16] == `LSTS_K_TRIG
                                 && dwl_len_r != set_len_r)
                            err_r <= `LSTS_ERR_LENGTH;
                        else if (set_len_r != DEPTH[AW:0]) begin
                            val_mem[set_len_r[AW-1:0]] <= I_PWDATA[17:0];
                            set_len_r <= set_len_r + 1'b1;
                        end
                    end
                    `LSTS_DWELL: begin
                        if (dwl_len_r != DEPTH[AW:0]) begin
                            dwl_mem[dwl_len_r[AW-1:0]] <= I_PWDATA[15:0];
                            dwl_len_r <= dwl_len_r + 1'b1;
                        end
                    end
                    `LSTS_LEVEL: begin
                        if (!typed)
                            volt_r <= 1'b1;
                        fill_val_r <= {`LSTS_K_DWELL, I_PWDATA[15:0]};
                        // Short segments are spread over ten points
                        if (lvl_dur < `LSTS_LVL_MIN_T) begin
                            fill_left_r <= `LSTS_LVL_POINTS;
                            fill_dwl_r  <= lvl_dur / `LSTS_LVL_POINTS;
                        end else begin
                            fill_left_r <= 4'h1;
                            fill_dwl_r  <= lvl_dur;
                        end
                    end
                    `LSTS_ERR:  err_r  <= 16'h0000;
                    `LSTS_MASK: mask_r <= I_PWDATA[3:0];
                    default: ;
                endcase
            end
        end
    end

    // Single tick base for dwell, timeout and pulse timing
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == `LSTS_TICK_CYC - 1) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // Step advance condition of the current state
    always @* begin
        adv = 1'b0;
        case (state_r)
            S_DWEL:  adv = tick_r & expired(step_cnt_r);
            S_WHI:   adv = trig_f | (wait_tmo_r != 16'h0000 & tick_r
                                     & expired(step_cnt_r));
            S_WLO:   adv = ~trig_f | (wait_tmo_r != 16'h0000 & tick_r
                                      & expired(step_cnt_r));
            default: adv = 1'b0;
        endcase
    end

    // Step sequencer
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_r     <= S_IDLE;
            idx_r       <= {AW{1'b0}};
            loop_r      <= 16'h0000;
            step_cnt_r  <= 16'h0000;
            pulse_cnt_r <= 16'h0000;
            pulse_act_r <= 1'b0;
            O_LEVEL     <= 16'h0000;
            O_RUNNING   <= 1'b0;
            ev_nxt      <= 4'h0;
        end else begin
            ev_nxt <= 4'h0;
            if (pulse_act_r & tick_r) begin
                if (expired(pulse_cnt_r))
                    pulse_act_r <= 1'b0;
                else
                    pulse_cnt_r <= pulse_cnt_r - 16'h0001;
            end
            if (!run_r) begin
                state_r     <= S_IDLE;
                O_RUNNING   <= 1'b0;
                pulse_act_r <= 1'b0;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (set_len_r != {(AW+1){1'b0}}) begin
                            idx_r     <= {AW{1'b0}};
                            loop_r    <= 16'h0000;
                            state_r   <= S_LOAD;
                            O_RUNNING <= 1'b1;
                        end
                    end
                    S_LOAD: begin
                        O_LEVEL <= cur_pt[15:0];
                        case (cur_pt[17:16])
                            `LSTS_K_WHIGH: begin
                                step_cnt_r <= wait_tmo_r;
                                state_r    <= S_WHI;
                            end
                            `LSTS_K_WLOW: begin
                                step_cnt_r <= wait_tmo_r;
                                state_r    <= S_WLO;
                            end
                            `LSTS_K_TRIG: begin
                                step_cnt_r  <= dwl_mem[idx_r];
                                pulse_cnt_r <= pulse_w_r;
                                pulse_act_r <= 1'b1;
                                state_r     <= S_DWEL;
                            end
                            default: begin
                                step_cnt_r <= dwl_mem[idx_r];
                                state_r    <= S_DWEL;
                            end
                        endcase
                    end
                    S_DWEL, S_WHI, S_WLO: begin
                        if (tick_r & ~adv)
                            step_cnt_r <= step_cnt_r - 16'h0001;
                        if (adv) begin
                            ev_nxt[`LSTS_ST_STEP] <= 1'b1;
                            if (state_r != S_DWEL && tick_r && expired(step_cnt_r)
                                && wait_tmo_r != 16'h0000)
                                ev_nxt[`LSTS_ST_TMO] <= 1'b1;
                            if ({1'b0, idx_r} + 1'b1 < set_len_r) begin
                                idx_r   <= idx_r + 1'b1;
                                state_r <= S_LOAD;
                            end else if (loop_r + 16'h0001 < loops_r) begin
                                loop_r  <= loop_r + 16'h0001;
                                idx_r   <= (skip_r < {{(15-AW){1'b0}}, set_len_r})
                                           ? skip_r[AW-1:0] : {AW{1'b0}};
                                state_r <= S_LOAD;
                            end else begin
                                ev_nxt[`LSTS_ST_DONE] <= 1'b1;
                                O_RUNNING <= 1'b0;
                                state_r   <= S_DONE;
                            end
                        end
                    end
                    S_DONE: state_r <= S_DONE;
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // Sticky status, write one to clear, set wins
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sts_r <= 4'h0;
            O_IRQ <= 1'b0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (ev_nxt[i] || (i == `LSTS_ST_ERR && wr && I_PADDR == `LSTS_POINT
                    && (!typed || (I_PWDATA[17:16] == `LSTS_K_TRIG
                        && (!pulse_set_r || dwl_len_r != set_len_r)))))
                    sts_r[i] <= 1'b1;
                else if (wr && I_PADDR == `LSTS_STATUS && I_PWDATA[i])
                    sts_r[i] <= 1'b0;
            end
            O_IRQ <= |(sts_r & mask_r);
        end
    end

    // Flag transistor: output trigger after setup, else output-off flag
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST)
            O_FLAG_TRANSISTOR_ON <= 1'b0;
        else if (pulse_set_r)
            O_FLAG_TRANSISTOR_ON <= pulse_act_r ? pulse_on_r : ~pulse_on_r;
        else
            O_FLAG_TRANSISTOR_ON <= I_OUTPUT_OFF;
    end
endmodule

// file: testbench/lsts_sva.sv
// Checker on the sequencer top ports
// Assumes it is bound to lsts_sequencer below
`timescale 1ns/1ps
`include "lsts_regs.vh"
module lsts_sva (
    input wire        I_REF_CLK,
    input wire        I_NRST,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [7:0]  I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire        I_OUTPUT_OFF,
    input wire        O_FLAG_TRANSISTOR_ON,
    input wire        O_RUNNING,
    input wire        O_IRQ
);
    wire       wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    reg        run_r;
    reg        pul_r;
    reg [31:0] msk_r;
    // Shadow of run, pulse setup and mask
    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            run_r <= 1'b0;
            pul_r <= 1'b0;
            msk_r <= 32'h0;
        end else if (wr) begin
            if (I_PADDR == `LSTS_CTRL)
                run_r <= I_PWDATA[`LSTS_CTRL_RUN];
            if (I_PADDR == `LSTS_CTRL && I_PWDATA[`LSTS_CTRL_CLEAR])
                pul_r <= 1'b0;
            if (I_PADDR == `LSTS_PULSE)
                pul_r <= 1'b1;
            if (I_PADDR == `LSTS_MASK)
                msk_r <= I_PWDATA;
        end
    end
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_NRST);
    property p_rdy_acc;
        O_PREADY |-> I_PSEL && I_PENABLE;
    endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
    property p_wait;
        I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
    endproperty
    a_wait: assert property (p_wait) else $error("more than one wait state");
    property p_slv_rdy;
        O_PSLVERR |-> O_PREADY;
    endproperty
    a_slv_rdy: assert property (p_slv_rdy) else $error("error without ready");
    property p_slv_zero;
        O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0;
    endproperty
    a_slv_zero: assert property (p_slv_zero) else $error("refused read not zero");
    property p_run_cause;
        $rose(O_RUNNING) |-> run_r;
    endproperty
    a_run_cause: assert property (p_run_cause) else $error("running without run");
    property p_run_stop;
        wr && I_PADDR == `LSTS_CTRL && !I_PWDATA[0] |-> ##[1:4] !O_RUNNING;
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("run clear ignored");
    property p_flag_idle;
        (!pul_r && $stable(I_OUTPUT_OFF)) [*3] |-> O_FLAG_TRANSISTOR_ON == I_OUTPUT_OFF;
    endproperty
    a_flag_idle: assert property (p_flag_idle) else $error("flag not output off");
    property p_irq_mask;
        (msk_r == 32'h0) [*2] |-> !O_IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
endmodule
bind lsts_sequencer lsts_sva u_sva (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_OUTPUT_OFF(I_OUTPUT_OFF), .O_FLAG_TRANSISTOR_ON(O_FLAG_TRANSISTOR_ON),
    .O_RUNNING(O_RUNNING), .O_IRQ(O_IRQ));

// file: testbench/lsts_trig_host.sv
// Host driving the trigger pin
// Assumes the bench calls its tasks; pin idles high like an open input
`timescale 1ns/1ps
module lsts_trig_host (
    input  wire i_clk,
    output reg  o_trig
);
    initial o_trig = 1'b1;
    task set(input logic v);
        @(posedge i_clk);
        o_trig <= v;
    endtask
    // Positive pulse of w cycles
    task pulse(input int w);
        set(1'b1);
        repeat (w) @(posedge i_clk);
        o_trig <= 1'b0;
    endtask
endmodule

// file: testbench/list_step_trigger_sequencer_tb_top.sv
// Self-checking bench of the list step sequencer
// Assumes APB master here, trigger host model, filter shortened to 20
`timescale 1ns/1ps
`include "lsts_regs.vh"
module list_step_trigger_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        ooff = 1'b0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] level;
    wire         flag;
    wire         running;
    wire         irq;
    wire         trig;
    logic [31:0] q;
    logic        e;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cnt = 0;
    lsts_sequencer #(.FILT_CYC(20)) dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TRIGGER_IN(trig),
        .I_OUTPUT_OFF(ooff), .O_LEVEL(level), .O_FLAG_TRANSISTOR_ON(flag),
        .O_RUNNING(running), .O_IRQ(irq));
    lsts_trig_host u_host (.i_clk(clk), .o_trig(trig));
    initial forever #5 clk = ~clk;
    task stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (cnt == 80000) begin
            n_mismatch++;
            stop_test;
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", n, x, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("wait", n, 32'h2);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, q & m, x);
    endtask
    task t_regs;
        rdc("tmo", `LSTS_WAIT_TMO, 32'hFFFF, 32'h0);
        rdc("loop", `LSTS_LOOP, 32'hFFFFFFFF, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        chk("slverr", 32'(e), 32'h1);
        chk("rdz", q, 32'h0);
        apb(1'b1, `LSTS_WAIT_TMO, 32'h5);
        rdc("tmo", `LSTS_WAIT_TMO, 32'hFFFF, 32'(`LSTS_WAIT_MIN_T));
        apb(1'b1, `LSTS_WAIT_TMO, 32'hFA0);
        rdc("tmo", `LSTS_WAIT_TMO, 32'hFFFF, 32'(`LSTS_WAIT_MAX_T));
        apb(1'b1, `LSTS_WAIT_TMO, 32'h0);
        rdc("tmo", `LSTS_WAIT_TMO, 32'hFFFF, 32'h0);
    endtask
    task t_err;
        apb(1'b1, `LSTS_POINT, 32'h0);
        rdc("err", `LSTS_ERR, 32'hFFFF, 32'(`LSTS_ERR_CONFLICT));
        apb(1'b1, `LSTS_CTRL, 32'h2);
        apb(1'b1, `LSTS_ERR, 32'h0);
        apb(1'b1, `LSTS_POINT, 32'h30000);
        rdc("err", `LSTS_ERR, 32'hFFFF, 32'(`LSTS_ERR_CONFLICT));
        apb(1'b1, `LSTS_PULSE, 32'h19);
        apb(1'b1, `LSTS_POINT, 32'h0);
        apb(1'b1, `LSTS_POINT, 32'h30000);
        rdc("err", `LSTS_ERR, 32'hFFFF, 32'(`LSTS_ERR_LENGTH));
        rdc("len", `LSTS_LEN, 32'hFFFFFFFF, 32'h1);
        apb(1'b1, `LSTS_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, `LSTS_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq", 32'(irq), 32'h0);
    endtask
    task t_lvl;
        apb(1'b1, `LSTS_CTRL, 32'h8);
        apb(1'b1, `LSTS_LEVEL, {16'd100, 16'h5});
        repeat (20) @(posedge clk);
        rdc("len", `LSTS_LEN, 32'hFFFFFFFF, {2{16'(`LSTS_LVL_POINTS)}});
        apb(1'b1, `LSTS_LEVEL, {16'd400, 16'h5});
        repeat (20) @(posedge clk);
        rdc("len", `LSTS_LEN, 32'hFFFFFFFF, {2{16'(`LSTS_LVL_POINTS + 1)}});
    endtask
    task t_edge;
        apb(1'b1, `LSTS_CTRL, 32'h8);
        apb(1'b1, `LSTS_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `LSTS_POINT, {14'h0, 2'(i % 2 + 1), 16'(i / 2 + 1)});
            apb(1'b1, `LSTS_DWELL, 32'h1);
        end
        apb(1'b1, `LSTS_LOOP, {16'd2, 16'd2});
        u_host.set(1'b0);
        u_host.pulse(40);
        repeat (40) @(posedge clk);
        chk("run", 32'(running), 32'h0);
        apb(1'b1, `LSTS_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        chk("lvl", 32'(level), 32'h1);
        u_host.pulse(5);
        repeat (40) @(posedge clk);
        rdc("pos", `LSTS_POS, 32'hFFFF, 32'h0);
        u_host.pulse(40);
        rdc("pos", `LSTS_POS, 32'hFFFF, 32'h1);
        chk("lvl", 32'(level), 32'h1);
        repeat (40) @(posedge clk);
        chk("lvl", 32'(level), 32'h2);
        u_host.pulse(40);
        repeat (40) @(posedge clk);
        rdc("pos", `LSTS_POS, 32'hFFFF, 32'h2);
        chk("run", 32'(running), 32'h1);
        u_host.pulse(40);
        repeat (40) @(posedge clk);
        chk("run", 32'(running), 32'h0);
        rdc("done", `LSTS_STATUS, 32'h4, 32'h4);
    endtask
    task t_trig;
        logic [17:0] pts [4];
        pts = '{18'h30007, 18'h10007, 18'h10007, 18'h00009};
        ooff <= 1'b1;
        apb(1'b1, `LSTS_CTRL, 32'h8);
        repeat (5) @(posedge clk);
        chk("flag", 32'(flag), 32'h1);
        apb(1'b1, `LSTS_PULSE, 32'h80000019);
        apb(1'b1, `LSTS_WAIT_TMO, 32'h19);
        apb(1'b1, `LSTS_LOOP, 32'h1);
        apb(1'b1, `LSTS_CTRL, 32'h2);
        chk("flag", 32'(flag), 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `LSTS_POINT, {14'h0, pts[i]});
            apb(1'b1, `LSTS_DWELL, 32'h1);
        end
        apb(1'b1, `LSTS_CTRL, 32'h3);
        repeat (2000) @(posedge clk);
        chk("flag", 32'(flag), 32'h1);
        chk("lvl", 32'(level), 32'h7);
        repeat (28000) @(posedge clk);
        chk("flag", 32'(flag), 32'h0);
        repeat (15000) @(posedge clk);
        chk("lvl", 32'(level), 32'h7);
        repeat (15000) @(posedge clk);
        chk("lvl", 32'(level), 32'h9);
        rdc("tmo", `LSTS_STATUS, 32'h8, 32'h8);
        apb(1'b1, `LSTS_CTRL, 32'h8);
        repeat (5) @(posedge clk);
        chk("flag", 32'(flag), 32'h1);
    endtask
    initial begin
        {psel, pen, pwr, paddr, pwdata} <= '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_err;
        t_lvl;
        t_edge;
        t_trig;
        stop_test;
    end
endmodule
